// ---- src/asra_pkg.sv ----
// package: shared constants and types for the converter readout link
`default_nettype none
package asra_pkg;
  localparam int RESULT_BITS = 32;
  localparam int BYTE_BITS = 8;
  localparam int BYTES_PER_RESULT = 4;
  localparam int CLK_MHZ = 250;
  localparam int SCLK_MAX_KHZ = 2000;
  // half period of the serial clock, rounded up so the rate stays at or below the limit
  localparam int SCLK_HALF_CYC = (CLK_MHZ * 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
  localparam int NOTCH_50_HZ = 50;
  localparam int NOTCH_60_HZ = 60;
  localparam int NOTCH_55_HZ = 55;
  localparam int CONV_CYC_DEFAULT = 20000;
  localparam int FIFO_DEPTH = 16;
  localparam int EXT_EDGES_DEFAULT = 64;
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    ASRA_NOTCH_60,
    ASRA_NOTCH_50,
    ASRA_NOTCH_55,
    ASRA_NOTCH_EXT
  } asra_notch_e;
endpackage : asra_pkg
`default_nettype wire

// ---- src/asra_link_if.sv ----
// interface: three-wire serial link between converter and host
`default_nettype none
interface asra_link_if;
  logic cs_n;
  logic sclk;
  logic sdo;
  logic sdo_oe_n;
  modport dev (input cs_n, input sclk, output sdo, output sdo_oe_n);
  modport host (output cs_n, output sclk, input sdo, input sdo_oe_n);
endinterface : asra_link_if
`default_nettype wire

// ---- src/asra_fifo.sv ----
// module: small synchronous fifo with valid/ready on both sides
`default_nettype none
module asra_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage needs no reset; only counted words are ever read
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule : asra_fifo
`default_nettype wire

// ---- src/asra_device.sv ----
// module: converter end of the link, conversion timing and result shift-out
`default_nettype none
module asra_device
  import asra_pkg::*;
#(
  parameter bit DUAL_NOTCH = 1'b0,
  parameter int CONV_CYC = CONV_CYC_DEFAULT,
  parameter int EXT_EDGES = EXT_EDGES_DEFAULT
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link
  asra_link_if.dev link,
  // converter side
  input wire logic notch_select_pin,
  input wire logic [RESULT_BITS-1:0] sample_data,
  output logic [1:0] notch_mode,
  output logic conv_busy
);
  typedef enum logic [1:0] {ASRA_CONV, ASRA_READY, ASRA_SHIFT, ASRA_DONE} asra_dst_e;
  asra_dst_e st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [RESULT_BITS-1:0] sh_r, sh_nxt;
  logic [5:0] bit_r, bit_nxt;
  logic sclk_d_r, pin_d_r, pin_seen_r, ext_r, ext_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic sclk_rise, sclk_fall, pin_edge, tick;

  assign sclk_rise = link.sclk && !sclk_d_r;
  assign sclk_fall = !link.sclk && sclk_d_r;
  // no edge before the first sample after reset, whatever the strap level
  assign pin_edge = pin_seen_r && (notch_select_pin != pin_d_r);
  // external clock: each pin edge advances the conversion
  assign tick = ext_r ? pin_edge : 1'b1;

  always_comb begin
    mode_nxt = mode_r;
    ext_nxt = ext_r;
    if (pin_edge) begin
      ext_nxt = 1'b1;
    end
    if (ext_r) begin
      mode_nxt = ASRA_NOTCH_EXT;
    end else if (DUAL_NOTCH) begin
      mode_nxt = notch_select_pin ? ASRA_NOTCH_50 : ASRA_NOTCH_55;
    end else begin
      mode_nxt = notch_select_pin ? ASRA_NOTCH_50 : ASRA_NOTCH_60;
    end
  end

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    unique case (st_r)
      ASRA_CONV: begin
        if (tick) begin
          cnt_nxt = cnt_r + 32'd1;
        end
        if (cnt_r >= 32'(ext_r ? EXT_EDGES : CONV_CYC)) begin
          st_nxt = ASRA_READY;
          sh_nxt = sample_data;
          bit_nxt = '0;
        end
      end
      ASRA_READY: begin
        // mode 0: first bit is on the wire before the first rising edge
        if (!link.cs_n && sclk_rise) begin
          st_nxt = ASRA_SHIFT;
        end
      end
      ASRA_SHIFT: begin
        if (sclk_fall) begin
          sh_nxt = {sh_r[RESULT_BITS-2:0], 1'b0};
          bit_nxt = bit_r + 6'd1;
          if (bit_r == 6'(BYTES_PER_RESULT * BYTE_BITS - 1)) begin
            st_nxt = ASRA_DONE;
          end
        end
      end
      ASRA_DONE: begin
      end
    endcase
    // deselect after a completed readout starts a new conversion
    if (link.cs_n && st_r == ASRA_DONE) begin
      st_nxt = ASRA_CONV;
      cnt_nxt = '0;
    end
    // aborted read reloads the current sample_data for the next select
    if (link.cs_n && st_r == ASRA_SHIFT) begin
      st_nxt = ASRA_READY;
      sh_nxt = sample_data;
      bit_nxt = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ASRA_CONV;
      cnt_r <= '0;
      sh_r <= RESULT_RST;
      bit_r <= '0;
      sclk_d_r <= 1'b0;
      pin_d_r <= 1'b0;
      pin_seen_r <= 1'b0;
      ext_r <= 1'b0;
      mode_r <= ASRA_NOTCH_60;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      sclk_d_r <= link.sclk;
      pin_d_r <= notch_select_pin;
      pin_seen_r <= 1'b1;
      ext_r <= ext_nxt;
      mode_r <= mode_nxt;
    end
  end

  // high while converting, then the result msb (low marks end of conversion)
  assign link.sdo = (st_r == ASRA_CONV) ? 1'b1 : sh_r[RESULT_BITS-1];
  assign link.sdo_oe_n = link.cs_n;
  assign notch_mode = mode_r;
  assign conv_busy = (st_r == ASRA_CONV);
endmodule : asra_device
`default_nettype wire

// ---- src/asra_host.sv ----
// module: host end, mode-0 serial master, result fifo and running averager
`default_nettype none
module asra_host
  import asra_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link
  asra_link_if.host link,
  // control
  input wire logic start,
  input wire logic avg_en,
  output logic busy,
  // result stream
  output logic res_valid,
  input wire logic res_ready,
  output logic [RESULT_BITS-1:0] res_data
);
  // Functional notes
  // - pin high gives 50Hz, low 60Hz
  // - dual variant: pin low gives 55Hz
  // - toggling notch pin becomes conversion clock
  // - output mean of previous and current sample
  // - select device before any transfer
  // - data high while converting; wait for low
  // - four bytes carry the 32-bit result
  // - deselect tri-states output, starts conversion
  // - clock idles low, sample first edge
  // - serial clock at most 2MHz
  typedef enum logic [2:0] {ASRH_IDLE, ASRH_WAIT, ASRH_HIGH, ASRH_LOW, ASRH_PUSH} asrh_st_e;
  // frame sequencer
  asrh_st_e st_r, st_nxt;
  logic cs_n_r, cs_n_nxt;
  logic [5:0] bit_r, bit_nxt;
  logic [RESULT_BITS-1:0] sh_r, sh_nxt;
  // serial clock timing
  logic sclk_r, sclk_nxt;
  logic [15:0] div_r, div_nxt;
  logic half_end, settle_end;
  // averager
  logic [RESULT_BITS-1:0] prev_r, prev_nxt, word;
  logic have_prev_r, have_prev_nxt;
  logic push, f_ready, take_word, eoc_seen;
  logic [RESULT_BITS:0] sum;

  // last system cycle of a serial clock half period
  function automatic logic half_over(input logic [15:0] cnt);
    return cnt == 16'(HALF_CYC - 1);
  endfunction : half_over

  // msb goes first, so the last index closes the frame
  function automatic logic last_bit(input logic [5:0] idx);
    return idx == 6'(BYTES_PER_RESULT * BYTE_BITS - 1);
  endfunction : last_bit

  // a released line never counts as end of conversion
  assign eoc_seen = !link.sdo_oe_n && !link.sdo;
  // 33-bit sum so two large results cannot wrap
  assign sum = {1'b0, prev_r} + {1'b0, sh_r};

  // serial clock timing: counts while waiting or shifting
  always_comb begin
    div_nxt = div_r;
    sclk_nxt = sclk_r;
    half_end = half_over(div_r);
    settle_end = (div_r >= 16'(HALF_CYC));
    unique case (st_r)
      ASRH_IDLE: begin
        div_nxt = '0;
      end
      ASRH_WAIT: begin
        div_nxt = (settle_end && eoc_seen) ? '0 : div_r + 16'd1;
      end
      ASRH_LOW: begin
        div_nxt = half_end ? '0 : div_r + 16'd1;
        if (half_end) begin
          sclk_nxt = 1'b1;
        end
      end
      ASRH_HIGH: begin
        div_nxt = half_end ? '0 : div_r + 16'd1;
        if (half_end) begin
          sclk_nxt = 1'b0;
        end
      end
      ASRH_PUSH: begin
        div_nxt = '0;
      end
      default: begin
        div_nxt = '0;
        sclk_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_r <= 1'b0;
      div_r <= '0;
    end else begin
      sclk_r <= sclk_nxt;
      div_r <= div_nxt;
    end
  end

  always_comb begin
    st_nxt = st_r;
    cs_n_nxt = cs_n_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    unique case (st_r)
      ASRH_IDLE: begin
        if (start) begin
          cs_n_nxt = 1'b0;
          st_nxt = ASRH_WAIT;
        end
      end
      ASRH_WAIT: begin
        // allow one half period for the output to settle after select
        if (settle_end && eoc_seen) begin
          st_nxt = ASRH_LOW;
          bit_nxt = '0;
        end
      end
      ASRH_LOW: begin
        if (half_end) begin
          sh_nxt = {sh_r[RESULT_BITS-2:0], link.sdo};
          st_nxt = ASRH_HIGH;
        end
      end
      ASRH_HIGH: begin
        if (half_end) begin
          bit_nxt = bit_r + 6'd1;
          st_nxt = last_bit(bit_r) ? ASRH_PUSH : ASRH_LOW;
        end
      end
      ASRH_PUSH: begin
        cs_n_nxt = 1'b1;
        // back-pressure: stay here until the fifo takes the word, unless the word only primes the averager
        if (take_word) begin
          st_nxt = ASRH_IDLE;
        end
      end
      default: begin
        st_nxt = ASRH_IDLE;
        cs_n_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ASRH_IDLE;
      cs_n_r <= 1'b1;
      bit_r <= '0;
      sh_r <= RESULT_RST;
    end else begin
      st_r <= st_nxt;
      cs_n_r <= cs_n_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
    end
  end

  // averager: history and the word handed to the fifo
  always_comb begin
    prev_nxt = prev_r;
    have_prev_nxt = have_prev_r;
    word = avg_en ? sum[RESULT_BITS:1] : sh_r;
    take_word = f_ready || (avg_en && !have_prev_r);
    push = 1'b0;
    if (st_r == ASRH_PUSH && take_word) begin
      // the first averaged result only primes the history
      push = !avg_en || have_prev_r;
      prev_nxt = sh_r;
      have_prev_nxt = 1'b1;
    end
    if (!avg_en) begin
      have_prev_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= RESULT_RST;
      have_prev_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      have_prev_r <= have_prev_nxt;
    end
  end

  asra_fifo #(.WIDTH(RESULT_BITS), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(f_ready),
    .in_data(word),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign busy = (st_r != ASRH_IDLE);
endmodule : asra_host
`default_nettype wire

// ---- sim/asra_monitor.sv ----
// checker: serial link timing between converter and host
`default_nettype none
module asra_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic sdo_oe_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic sclk_r, sclk_nxt;
  logic [5:0] rises_r, rises_nxt;
  always_comb begin
    sclk_nxt = sclk;
    rises_nxt = rises_r;
    if (cs_n) begin
      rises_nxt = 6'h00;
    end else if (sclk && !sclk_r) begin
      rises_nxt = rises_r + 6'h01;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_r <= 1'b0;
      rises_r <= 6'h00;
    end else begin
      sclk_r <= sclk_nxt;
      rises_r <= rises_nxt;
    end
  end
  sequence s_select;
    $fell(cs_n);
  endsequence
  sequence s_deselect;
    $rose(cs_n);
  endsequence
  a_oe_tracks_select: assert property (sdo_oe_n == cs_n)
    else $error("output enable does not follow select");
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock not low while deselected");
  a_select_before_clock: assert property ($rose(sclk) |-> $past(cs_n, 2) == 1'b0)
    else $error("serial clock before select");
  a_sclk_high_min: assert property ($rose(sclk) |-> sclk [*2])
    else $error("serial clock high phase too short");
  a_sclk_low_min: assert property ($fell(sclk) |-> !sclk [*2])
    else $error("serial clock low phase too short");
  a_wait_for_eoc: assert property (s_select |-> !sclk throughout (##[1:1000] !sdo))
    else $error("clocked before end of conversion or no end of conversion");
  a_data_steady_high: assert property (sclk && $past(sclk) && !cs_n |-> $stable(sdo))
    else $error("data moved while serial clock high");
  a_frame_bits: assert property (s_deselect |-> rises_r == 6'd32)
    else $error("frame did not carry 32 clocks");
  a_restart_conv: assert property (s_deselect |-> ##2 sdo [*8])
    else $error("no new conversion after deselect");
endmodule : asra_monitor
`default_nettype wire

// ---- sim/tb.sv ----
// testbench: both link ends, result fifo, averaging and notch modes
`default_nettype none
module tb import asra_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic pin = 1'b0;
  logic start = 1'b0;
  logic avg_en = 1'b0;
  logic res_ready = 1'b1;
  logic [31:0] smp = 32'h0000_0000;
  logic busy, res_valid, conv_busy;
  logic [1:0] mode, mode2;
  logic [31:0] res_data;
  logic [31:0] got[$];
  int miscompares = 0;
  int checked = 0;
  asra_link_if link_i ();
  asra_link_if link2_i ();
  // the dual-notch device follows the same frames; only its notch mode is judged
  assign link2_i.cs_n = link_i.cs_n;
  assign link2_i.sclk = link_i.sclk;
  asra_device #(.CONV_CYC(100), .EXT_EDGES(4)) asra_device_i (.clock(clock), .rst_n(rst_n),
    .link(link_i.dev), .notch_select_pin(pin), .sample_data(smp), .notch_mode(mode),
    .conv_busy(conv_busy));
  asra_device #(.DUAL_NOTCH(1'b1), .CONV_CYC(100)) asra_device_dual_i (.clock(clock),
    .rst_n(rst_n), .link(link2_i.dev), .notch_select_pin(pin), .sample_data(smp),
    .notch_mode(mode2), .conv_busy());
  asra_host #(.HALF_CYC(2)) asra_host_i (.clock(clock), .rst_n(rst_n),
    .link(link_i.host), .start(start), .avg_en(avg_en), .busy(busy), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data));
  asra_monitor asra_monitor_i (.clock(clock), .rst_n(rst_n), .cs_n(link_i.cs_n),
    .sclk(link_i.sclk), .sdo(link_i.sdo), .sdo_oe_n(link_i.sdo_oe_n));
  initial begin
    forever #2 clock = ~clock;
  end
  // pre-edge values, the same ones the fifo sees
  always @(posedge clock) begin
    if (rst_n && res_valid && res_ready) begin
      got.push_back(res_data);
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic final_report;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  // pin level is set inside reset: any edge later means external clock
  task automatic do_reset(input logic p);
    rst_n <= 1'b0;
    pin <= p;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : do_reset
  task automatic kick;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    @(posedge clock);
  endtask : kick
  // bit 31 kept low: it is the end-of-conversion slot
  task automatic rd(input logic [31:0] s);
    int n;
    n = 0;
    smp <= s;
    kick();
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, busy}, 32'h0);
  endtask : rd
  task automatic take(input logic [31:0] e);
    int n;
    n = 0;
    while (got.size() == 0 && n < 500) begin
      @(posedge clock);
      n++;
    end
    chk(got.size() > 0 ? got.pop_front() : 'x, e);
  endtask : take
  task automatic t_notch;
    do_reset(1'b1);
    chk({30'h0, mode}, 32'h1);
    do_reset(1'b0);
    chk({30'h0, mode}, 32'h0);
    chk({30'h0, mode2}, 32'h2);
    $display("t_notch done");
  endtask : t_notch
  task automatic t_read;
    rd(32'h1234_5678);
    take(32'h1234_5678);
    // the restart lands on the edge after deselect; look one edge later
    @(posedge clock);
    chk({31'h0, conv_busy}, 32'h1);
    rd(32'h7fff_fffe);
    take(32'h7fff_fffe);
    $display("t_read done");
  endtask : t_read
  task automatic t_avg;
    avg_en <= 1'b1;
    rd(32'h0000_0010);
    repeat (4) @(posedge clock);
    chk({31'h0, res_valid}, 32'h0);
    rd(32'h7fff_fff0);
    take(32'h4000_0000);
    rd(32'h0000_0030);
    take(32'h4000_0010);
    avg_en <= 1'b0;
    $display("t_avg done");
  endtask : t_avg
  task automatic t_fifo;
    res_ready <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd(32'h0100_0000 + i);
    end
    smp <= 32'h0200_0000;
    kick();
    repeat (400) @(posedge clock);
    chk({31'h0, busy}, 32'h1);
    res_ready <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      take(32'h0100_0000 + i);
    end
    take(32'h0200_0000);
    $display("t_fifo done");
  endtask : t_fifo
  task automatic t_ext;
    do_reset(1'b0);
    fork
      repeat (300) begin
        repeat (5) @(posedge clock);
        pin <= ~pin;
      end
    join_none
    rd(32'h0abc_def0);
    take(32'h0abc_def0);
    chk({30'h0, mode}, 32'h3);
    // pin edges pace the next conversion: about 20 cycles instead of 100
    repeat (40) @(posedge clock);
    chk({31'h0, conv_busy}, 32'h0);
    $display("t_ext done");
  endtask : t_ext
  initial begin
    t_notch();
    t_read();
    t_avg();
    t_fifo();
    t_ext();
    final_report();
  end
  initial begin
    #80000;
    miscompares++;
    final_report();
  end
endmodule : tb
`default_nettype wire
